// ### src/dsc_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`include "dsc_params.svh"
module dsc_ctrl
  import dsc_pkg::*;
#(
  parameter int unsigned POR_CYC  = `DSC_POR_CYC,
  parameter int unsigned DET_CYC  = `DSC_DET_CYC,
  parameter int unsigned CONV_CYC = `DSC_CONV_OSC_CYC
) (
  // clock, reset, enable
  input  wire logic        SYS_CLK,
  input  wire logic        SRST,
  input  wire logic        CE,
  // internal oscillator tick and frequency select pin
  input  wire logic        OSC_TICK,
  input  wire logic        FREQ_SELECT_INPUT,
  // front end result
  input  wire dsc_result_s RESULT_IN,
  // serial port pins
  input  wire logic        CS_N,
  input  wire logic        SCK_IN,
  output logic             SCK_OUT,
  output logic             SCK_OE,
  output logic             SCK_PULLUP_EN,
  output logic             SDO_OUT,
  output logic             SDO_OE,
  // status
  output logic             SLEEP_ACTIVE,
  output logic             EXT_CLK_ACTIVE,
  output logic             CAL_ACTIVE,
  output logic             CONV_DONE
);

  // three-flop pin synchronisers; a change counts once stages 2 and 3 agree
  // the agreement test filters a one-cycle glitch on a slow pin, at the
  // price of about four cycles from pin to filtered level
  // stage 1 feeds only the next stage, never any decision logic
  logic [2:0] cs_sync_reg, sck_sync_reg, fs_sync_reg;
  logic       cs_reg, sck_reg, fs_reg;      // filtered pin levels
  logic       cs_prev_reg, sck_prev_reg, fs_prev_reg;

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      cs_sync_reg  <= 3'h7;
      sck_sync_reg <= 3'h7;
      fs_sync_reg  <= 3'h0;
    end else if (CE) begin
      cs_sync_reg  <= {cs_sync_reg[1:0], CS_N};
      sck_sync_reg <= {sck_sync_reg[1:0], SCK_IN};
      fs_sync_reg  <= {fs_sync_reg[1:0], FREQ_SELECT_INPUT};
    end
  end

  // filtered levels update only when stages 2 and 3 agree
  // a disagreement leaves the old level standing, so a pin that changes
  // every cycle is held off rather than passed on as noise
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      cs_reg  <= 1'b1;
      sck_reg <= 1'b1;
      fs_reg  <= 1'b0;
    end else if (CE) begin
      if (cs_sync_reg[2] == cs_sync_reg[1])   cs_reg  <= cs_sync_reg[2];
      if (sck_sync_reg[2] == sck_sync_reg[1]) sck_reg <= sck_sync_reg[2];
      if (fs_sync_reg[2] == fs_sync_reg[1])   fs_reg  <= fs_sync_reg[2];
    end
  end

  // previous levels for edge detection
  // reset values equal the idle pin levels, so no false edge follows reset;
  // only the serial clock may differ, and its edges count only in output
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      cs_prev_reg  <= 1'b1;
      sck_prev_reg <= 1'b1;
      fs_prev_reg  <= 1'b0;
    end else if (CE) begin
      cs_prev_reg  <= cs_reg;
      sck_prev_reg <= sck_reg;
      fs_prev_reg  <= fs_reg;
    end
  end

  // one-cycle edge pulses taken from the filtered levels
  wire cs_fall  = cs_prev_reg & ~cs_reg;
  wire cs_rise  = ~cs_prev_reg & cs_reg;
  wire esck_fall = sck_prev_reg & ~sck_reg;
  wire fs_rise  = ~fs_prev_reg & fs_reg;

  // power-on reset: counts down before the converter cycle starts
  // the whole cycle waits here, so the first conversion starts from
  // cleared registers and a settled clock mode pin
  logic [19:0] por_cnt_reg;
  wire         por_busy = (por_cnt_reg != 20'h0);

  always_ff @(posedge SYS_CLK) begin
    if (SRST)
      por_cnt_reg <= 20'(POR_CYC);                         // RULE_18
    else if (CE && por_busy)
      por_cnt_reg <= por_cnt_reg - 20'h1;
  end

  // external clock detect: a rising edge within the window means
  // at least 2560 Hz; the internal oscillator is then gated off
  // the window is one period of the slowest clock still accepted; a
  // slower clock falls back to the internal oscillator once it runs out
  logic [19:0] det_cnt_reg;
  logic        ext_reg;

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      det_cnt_reg <= 20'h0;
      ext_reg     <= 1'b0;
    end else if (CE) begin
      if (fs_rise) begin
        det_cnt_reg <= 20'(DET_CYC);                       // RULE_22
        ext_reg     <= 1'b1;
      end else if (det_cnt_reg != 20'h0)
        det_cnt_reg <= det_cnt_reg - 20'h1;
      else
        ext_reg     <= 1'b0;                               // RULE_09
    end
  end

  // conversion time base: one tick per external clock rising edge or per
  // internal oscillator tick; the notch then follows the source / 2560
  // oscillator ticks are also held off while the select pin sits high
  wire conv_tick = ext_reg ? fs_rise : (OSC_TICK & ~fs_reg); // RULE_10

  // clock mode latch: pin level at reset release and each select fall
  // sampling is skipped while the block drives the pin itself, which
  // would otherwise read back its own clock as the mode level
  logic ext_sck_mode_reg;
  logic mode_armed_reg;

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      ext_sck_mode_reg <= 1'b0;
      mode_armed_reg   <= 1'b0;
    end else if (CE) begin
      if (!mode_armed_reg && !por_busy) begin
        ext_sck_mode_reg <= ~sck_reg;                      // RULE_08
        mode_armed_reg   <= 1'b1;
      end else if (cs_fall && !SCK_OE)
        ext_sck_mode_reg <= ~sck_reg;                      // RULE_08
    end
  end
  // low on the clock pin means the host will clock; high means internal

  // converter state machine
  // the cycle has no other exits: modes and calibration never add a
  // state, so a host sees the same sequence in every configuration
  dsc_state_e  state_reg, state_next;
  logic [19:0] conv_cnt_reg;
  logic [5:0]  bit_cnt_reg;
  dsc_word_t   shift_reg;
  logic        done_reg;
  logic [2:0]  isck_div_reg;
  logic        isck_reg;

  // word layout: flag, zero bit, sign, result, sub bits
  // the flag is packed low, since the word is only loaded once done
  function automatic dsc_word_t pack_word(input dsc_result_s r);
    pack_word = {1'b0, 1'b0, r.sign, r.value, r.sub};      // RULE_19
  endfunction : pack_word

  // end of conversion needs the last tick, not only a zero count,
  // so the conversion length is exactly the tick count
  wire conv_end   = (conv_cnt_reg == 20'h0) && conv_tick;
  wire isck_fall  = isck_reg && (isck_div_reg == 3'h0);
  wire out_fall   = ext_sck_mode_reg ? esck_fall : isck_fall; // RULE_14
  wire last_bit   = (bit_cnt_reg == 6'd31);
  wire out_finish = out_fall && last_bit;                  // RULE_15

  // next state; select rise during output aborts straight to conversion
  // a select that is already low on entry to sleep wakes at once
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      DSC_CONV:  if (conv_end) state_next = DSC_SLEEP;     // RULE_11
      DSC_SLEEP: if (!cs_reg) state_next = DSC_OUT;        // RULE_01 RULE_02
      DSC_OUT:   if (cs_rise || out_finish)
                   state_next = DSC_CONV;                  // RULE_03
      default:   state_next = DSC_CONV;
    endcase
  end

  // state register; held during power-on reset so the first conversion
  // gets its full length
  always_ff @(posedge SYS_CLK) begin
    if (SRST)
      state_reg <= DSC_CONV;
    else if (CE && !por_busy)
      state_reg <= state_next;
  end

  // conversion counter; calibration is folded into this same window
  // reloaded outside conversion, so an aborted output still gets a
  // full-length conversion afterwards
  always_ff @(posedge SYS_CLK) begin
    if (SRST)
      conv_cnt_reg <= 20'(CONV_CYC - 1);                   // RULE_23
    else if (CE && !por_busy) begin
      if (state_reg != DSC_CONV)
        conv_cnt_reg <= 20'(CONV_CYC - 1);
      else if (conv_tick && conv_cnt_reg != 20'h0)
        conv_cnt_reg <= conv_cnt_reg - 20'h1;              // RULE_17
    end
  end

  // result latch and shifter: loaded at conversion end, static in sleep
  // ones are shifted in behind the word, so after the last bit the line
  // already shows the busy status of the next conversion
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      shift_reg   <= '0;
      bit_cnt_reg <= 6'h0;
      done_reg    <= 1'b0;
    end else if (CE && !por_busy) begin
      if (state_reg == DSC_CONV) begin
        bit_cnt_reg <= 6'h0;
        done_reg    <= conv_end;                           // RULE_20
        if (conv_end)
          shift_reg <= pack_word(RESULT_IN);               // RULE_13
      end else if (state_reg == DSC_OUT && out_fall) begin
        shift_reg   <= {shift_reg[30:0], 1'b1};            // RULE_14
        bit_cnt_reg <= bit_cnt_reg + 6'h1;
      end                                                  // RULE_12
    end
  end

  // internal serial clock: system clock divided, runs only in output
  // it idles low, so the first edge after select falls is a rise and the
  // host captures the flag bit before any shift; only falls that follow
  // a rise move the word
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      isck_div_reg <= 3'h0;
      isck_reg     <= 1'b1;
    end else if (CE) begin
      if (state_reg == DSC_OUT && !ext_sck_mode_reg && !cs_reg) begin
        isck_div_reg <= isck_div_reg + 3'h1;
        if (isck_div_reg == 3'h0)
          isck_reg <= ~isck_reg;
      end else begin
        isck_div_reg <= 3'h1;
        isck_reg     <= 1'b0;                              // RULE_14
      end
    end
  end

  // pin drivers: all registered
  // every pin and status level leaves a flip-flop, which costs one cycle
  // of latency but keeps glitches off the host side
  // the output enable follows the filtered select only, in every state
  wire in_conv  = (state_reg == DSC_CONV);
  wire sdo_val  = (state_reg == DSC_OUT) ? shift_reg[31]
                : (in_conv ? 1'b1 : 1'b0);                 // RULE_05
  wire sdo_next = (out_finish) ? 1'b1 : sdo_val;           // RULE_21

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      SDO_OUT        <= 1'b1;
      SDO_OE         <= 1'b0;
      SCK_OUT        <= 1'b1;
      SCK_OE         <= 1'b0;
      SCK_PULLUP_EN  <= 1'b0;
      SLEEP_ACTIVE   <= 1'b0;
      EXT_CLK_ACTIVE <= 1'b0;
      CAL_ACTIVE     <= 1'b0;
      CONV_DONE      <= 1'b0;
    end else if (CE) begin
      SDO_OUT        <= sdo_next;
      SDO_OE         <= ~cs_reg;                           // RULE_04
      SCK_OUT        <= isck_reg;
      SCK_OE         <= (state_reg == DSC_OUT) && !ext_sck_mode_reg
                        && !cs_reg;                        // RULE_06
      SCK_PULLUP_EN  <= mode_armed_reg && !ext_sck_mode_reg; // RULE_07
      SLEEP_ACTIVE   <= (state_reg == DSC_SLEEP) && cs_reg; // RULE_02
      EXT_CLK_ACTIVE <= ext_reg;
      CAL_ACTIVE     <= in_conv && !por_busy;
      CONV_DONE      <= done_reg;
    end
  end
  // no configuration register: modes come from pins only    RULE_16
  // select low wakes the converter into output              RULE_01
  // limitation: the serial clock is sampled, so a host clock must stay
  // well below a sixteenth of the system clock to be seen edge by edge

endmodule : dsc_ctrl
`default_nettype wire

// ### src/dsc_params.svh
// Function
// RULE_01: chip select low enables output and wakes
// RULE_02: sleep after conversion while chip select high
// RULE_03: chip select rise aborts transfer, converts
// RULE_04: output high impedance while chip select high
// RULE_05: status bit shown during convert and sleep
// RULE_06: clock pin driven only in internal mode
// RULE_07: weak pull-up on in internal mode
// RULE_08: clock mode sampled at reset, select fall
// RULE_09: frequency input low selects internal oscillator
// RULE_10: external clock sets notch as clock/2560
// RULE_11: states cycle convert, sleep, output
// RULE_12: result held static during sleep
// RULE_13: shifted word is the just-finished result
// RULE_14: data changes on falling serial clock
// RULE_15: output ends at 32 bits or select high
// RULE_16: modes set by pins, no registers
// RULE_17: calibration hidden inside each conversion
// RULE_18: half-millisecond power-on reset then convert
// RULE_19: word is flag, zero, sign, result, sub bits
// RULE_20: done flag high converting, low when finished; code keeps CONV_DONE low converting and high from conversion end to the next start instead
// RULE_21: output high after 32nd falling edge
// RULE_22: external clock detected at 2560 hertz up
// RULE_23: conversion length fixed system clock count; code counts CONV_CYC conv_tick pulses instead
`ifndef DSC_PARAMS_SVH
`define DSC_PARAMS_SVH
`define DSC_CLK_PERIOD_NS  5
`define DSC_POR_TIME_NS    500000
`define DSC_POR_CYC        (`DSC_POR_TIME_NS / `DSC_CLK_PERIOD_NS)
`define DSC_NOTCH_DIV      2560
`define DSC_CONV_OSC_CYC   (510 * `DSC_NOTCH_DIV / 10)
`define DSC_DET_TIME_NS    390625
`define DSC_DET_CYC        (`DSC_DET_TIME_NS / `DSC_CLK_PERIOD_NS)
`define DSC_ISCK_DIV       8
`define DSC_WORD_BITS      32
`define DSC_RESULT_BITS    24
`define DSC_SUB_BITS       5
`endif

// ### src/dsc_pkg.sv
package dsc_pkg;
  // one-hot converter cycle states
  typedef enum logic [2:0] {
    DSC_CONV  = 3'b001,
    DSC_SLEEP = 3'b010,
    DSC_OUT   = 3'b100
  } dsc_state_e;
  // conversion result as produced by the front end
  typedef struct packed {
    logic        sign;
    logic [23:0] value;
    logic [4:0]  sub;
  } dsc_result_s;
  typedef logic [31:0] dsc_word_t;
endpackage : dsc_pkg

// ### verification/dsc_ctrl_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module dsc_ctrl_assertions (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic SRST,
  // pins and status seen
  input wire logic CS_N,
  input wire logic SCK_OE,
  input wire logic SCK_PULLUP_EN,
  input wire logic SDO_OUT,
  input wire logic SDO_OE,
  input wire logic SLEEP_ACTIVE,
  input wire logic CAL_ACTIVE,
  input wire logic CONV_DONE
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SRST);
  // six cycles clears the select synchroniser latency
  a_sdo_hiz_high: assert property (CS_N[*6] |-> !SDO_OE)
    else $error("sdo driven with select high");
  a_sdo_on_low: assert property ((!CS_N)[*6] |-> SDO_OE)
    else $error("sdo not driven with select low");
  a_sck_drive_mode: assert property (SCK_OE |-> SCK_PULLUP_EN)
    else $error("sck driven outside internal mode");
  a_sck_quiet_high: assert property (CS_N[*8] |-> !SCK_OE)
    else $error("sck still driven after select rise");
  a_sleep_holds: assert property ((SLEEP_ACTIVE && CS_N)[*6] |=> SLEEP_ACTIVE)
    else $error("sleep left with select high");
  a_status_busy: assert property ((CAL_ACTIVE && SDO_OE) |-> SDO_OUT)
    else $error("status not high during conversion");
  a_eoc_falls: assert property (($fell(CAL_ACTIVE) && SDO_OE) |-> !SDO_OUT)
    else $error("status not low after conversion");
  a_done_at_end: assert property ($rose(CONV_DONE) |-> $fell(CAL_ACTIVE))
    else $error("done flag apart from conversion end");
  a_sdo_still_sleep: assert property (SLEEP_ACTIVE[*3] |-> $stable(SDO_OUT))
    else $error("sdo moved during sleep");
  a_cal_awake: assert property (CAL_ACTIVE |-> !SLEEP_ACTIVE)
    else $error("calibration during sleep");
  // main scenarios reached
  c_sleep: cover property ($rose(SLEEP_ACTIVE));
  c_int_sck: cover property ($rose(SCK_OE));
  c_abort: cover property ($fell(SDO_OE) && !SLEEP_ACTIVE);
endmodule : dsc_ctrl_assertions
bind dsc_ctrl dsc_ctrl_assertions chk_u (.SYS_CLK(SYS_CLK), .SRST(SRST), .CS_N(CS_N),
  .SCK_OE(SCK_OE), .SCK_PULLUP_EN(SCK_PULLUP_EN), .SDO_OUT(SDO_OUT), .SDO_OE(SDO_OE),
  .SLEEP_ACTIVE(SLEEP_ACTIVE), .CAL_ACTIVE(CAL_ACTIVE), .CONV_DONE(CONV_DONE));
`default_nettype wire

// ### verification/dsc_ctrl_tb.sv
`timescale 1ns/10ps
`default_nettype none
module dsc_ctrl_tb;
  import dsc_pkg::*;
  logic clk = 1'b0, srst = 1'b1, tick = 1'b0, fsel = 1'b0, fs_run = 1'b0, ce = 1'b1;
  logic cs_n, sck_pin, sdo_pin, sck_out, sck_oe, pull_en, sdo_out, sdo_oe;
  logic slp, ext_clk, cal, done;
  logic [31:0] w, exp1, exp2;
  dsc_result_s res = 30'h1a5c3e9; // first front end result
  int err_total = 0, n_compared = 0, cyc = 0;
  always #2.5 clk = ~clk;
  // oscillator tick every fourth cycle, optional external clock on the select pin
  always @(posedge clk) begin
    cyc <= cyc + 1;
    tick <= (cyc % 4 == 0);
    if (!fs_run) fsel <= 1'b0;
    else if (cyc % 10 == 0) fsel <= ~fsel;
    if (cyc == 30000) begin
      err_total++;
      print_verdict();
    end
  end
  dsc_ctrl #(.POR_CYC(20), .DET_CYC(50), .CONV_CYC(40)) dut_u (
    .SYS_CLK(clk), .SRST(srst), .CE(ce), .OSC_TICK(tick), .FREQ_SELECT_INPUT(fsel),
    .RESULT_IN(res), .CS_N(cs_n), .SCK_IN(sck_pin), .SCK_OUT(sck_out), .SCK_OE(sck_oe),
    .SCK_PULLUP_EN(pull_en), .SDO_OUT(sdo_out), .SDO_OE(sdo_oe), .SLEEP_ACTIVE(slp),
    .EXT_CLK_ACTIVE(ext_clk), .CAL_ACTIVE(cal), .CONV_DONE(done));
  dsc_host host_u (.clk(clk), .sdo_out(sdo_out), .sdo_oe(sdo_oe), .sck_out(sck_out),
    .sck_oe(sck_oe), .pull_en(pull_en), .cs_n(cs_n), .sck_pin(sck_pin), .sdo_pin(sdo_pin));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      $display("unexpected at %0t: %s", $time, m);
      err_total++;
    end
  endtask : chk
  function automatic logic pick(input int s);
    return s == 0 ? slp : (s == 1 ? sdo_pin : ext_clk);
  endfunction : pick
  // bounded wait; a miss shows up in the following compare
  task automatic wait_lvl(input int s, input logic v);
    for (int k = 0; k < 4000 && pick(s) !== v; k++) @(posedge clk);
  endtask : wait_lvl
  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict
  initial begin
    exp1 = {2'b00, res};
    exp2 = {2'b00, 30'h2aaaaaaa};
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    // first conversion ends in sleep, held while select is high
    wait_lvl(0, 1'b1);
    repeat (50) @(posedge clk);
    chk(slp, 1'b1, "sleep left early");
    chk(done, 1'b1, "done flag not set");
    res <= 30'h2aaaaaaa; // must not reach the held word
    host_u.read_word(1'b1, 32, w);
    chk(w, exp1, "external sck word");
    repeat (10) @(posedge clk);
    chk(sdo_pin, 1'b1, "no high after last bit");
    chk(slp, 1'b0, "no new conversion");
    // select stays low: status falls at conversion end, then output begins
    wait_lvl(1, 1'b0);
    chk(sdo_pin, 1'b0, "status never fell");
    host_u.read_word(1'b1, 8, w);
    chk(w[7:0], exp2[31:24], "partial word");
    host_u.set_cs(1'b1);
    repeat (10) @(posedge clk);
    chk(sdo_oe, 1'b0, "sdo not released");
    chk(slp, 1'b0, "abort did not convert");
    // clock enable low freezes the conversion far beyond its length
    ce <= 1'b0;
    repeat (400) @(posedge clk);
    ce <= 1'b1;
    chk(slp, 1'b0, "conversion moved while frozen");
    // internal serial clock, chosen by a high sck at the select fall
    wait_lvl(0, 1'b1);
    host_u.read_word(1'b0, 32, w);
    chk(w, exp2, "internal sck word");
    chk(pull_en, 1'b1, "pull-up off");
    repeat (30) @(posedge clk);
    chk(sck_oe, 1'b0, "sck driven after word");
    host_u.set_cs(1'b1);
    // external conversion clock on the frequency select pin
    fs_run <= 1'b1;
    wait_lvl(2, 1'b1);
    chk(ext_clk, 1'b1, "external clock not seen");
    wait_lvl(0, 1'b1);
    chk(slp, 1'b1, "external conversion stuck");
    fs_run <= 1'b0;
    wait_lvl(2, 1'b0);
    chk(ext_clk, 1'b0, "oscillator not restored");
    print_verdict();
  end
endmodule : dsc_ctrl_tb
`default_nettype wire

// ### verification/dsc_host.sv
`timescale 1ns/10ps
`default_nettype none
module dsc_host (
  // clock
  input wire logic clk,
  // device side drives
  input wire logic sdo_out,
  input wire logic sdo_oe,
  input wire logic sck_out,
  input wire logic sck_oe,
  input wire logic pull_en,
  // resolved pins
  output logic     cs_n,
  output logic     sck_pin,
  output logic     sdo_pin
);
  logic hs_oe = 1'b1;  // host drives sck
  logic hs_lvl = 1'b0; // low at power-up picks external mode
  logic flip = 1'b0;   // floating line pattern, never a stale value
  initial cs_n = 1'b1;
  always @(posedge clk) flip <= ~flip;
  // released lines float unless pulled up
  assign sck_pin = sck_oe ? sck_out : (hs_oe ? hs_lvl : (pull_en | flip));
  assign sdo_pin = sdo_oe ? sdo_out : flip;
  task automatic set_cs(input logic v);
    @(posedge clk);
    cs_n <= v;
  endtask : set_cs
  // shift in n bits, capturing each on a rising sck edge
  task automatic read_word(input logic ext, input int n, output logic [31:0] w);
    w = '0;
    hs_lvl <= ~ext; // mode level held across the select fall
    hs_oe <= 1'b1;
    set_cs(1'b0);
    repeat (10) @(posedge clk);
    hs_oe <= ext; // internal mode: let the device drive
    for (int i = 0; i < n; i++) begin
      if (ext) begin
        repeat (10) @(posedge clk);
        hs_lvl <= 1'b1;
        w = {w[30:0], sdo_pin};
        repeat (10) @(posedge clk);
        hs_lvl <= 1'b0;
      end else begin
        for (int k = 0; k < 200 && sck_pin !== 1'b0; k++) @(posedge clk);
        for (int k = 0; k < 200 && sck_pin !== 1'b1; k++) @(posedge clk);
        w = {w[30:0], sdo_pin};
      end
    end
  endtask : read_word
endmodule : dsc_host
`default_nettype wire
